// ===== mb_master_model.sv
// Partner model: master that sends request frames and sinks the reply stream
`timescale 1ns/100ps
module mb_master_model (
  input  wire logic               clk,
  output      mb_pkg::byte_beat_t rxBeat,
  input  wire mb_pkg::byte_beat_t txBeat,
  output      logic               txReady
);
  initial begin
    rxBeat  = '0;
    txReady = 1'b1;
  end

  // ----------------------------------------------------------------
  // Request side
  // ----------------------------------------------------------------
  // master originates frames
  task automatic send(input logic [7:0] req [$]);
    for (int i = 0; i < req.size(); i++) begin
      @(posedge clk);
      #1;
      rxBeat.valid = 1'b1;
      rxBeat.last  = (i == req.size() - 1);
      rxBeat.data  = req[i];
    end
    @(posedge clk);
    #1;
    // Released line shows inverted data, so a stale byte never looks valid
    rxBeat.valid = 1'b0;
    rxBeat.last  = 1'b0;
    rxBeat.data  = ~rxBeat.data;
  endtask

  // ----------------------------------------------------------------
  // Reply side
  // ----------------------------------------------------------------
  // reply collected after request
  task automatic recv(input bit slow, output logic [7:0] got [$], output bit ok);
    got = {};
    ok  = 1'b0;
    for (int n = 0; n < 200 && !ok; n++) begin
      // Look mid-cycle at what the next rising edge will take
      @(negedge clk);
      if (txReady === 1'b1 && txBeat.valid === 1'b1) begin
        got.push_back(txBeat.data);
        ok = (txBeat.last === 1'b1);
      end
      @(posedge clk);
      #1;
      // Slow sink stalls every other cycle to exercise the hold of txBeat
      txReady = (slow && !ok && n < 199) ? ~txReady : 1'b1;
    end
  endtask
endmodule

// ===== mb_pkg.sv
// Package: frame layout constants, codes and carrier types for the frame responder
package mb_pkg;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned HDR_LEN      = 6;
  localparam logic [7:0]  PROTO_ID     = 8'h00;
  localparam logic [7:0]  LEN_HI       = 8'h00;
  localparam logic [7:0]  ADDR_BCAST   = 8'h00;
  localparam logic [7:0]  ADDR_MAX     = 8'hf7;
  localparam logic [4:0]  OWN_DEFAULT  = 5'h01;
  localparam logic [7:0]  ERR_BIT      = 8'h80;
  localparam int unsigned REQ_LEN      = 6;
  localparam int unsigned COIL_DATA_AT = 3;
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FC_RD_COIL  = 8'h01;
  localparam logic [7:0] FC_RD_DIN   = 8'h02;
  localparam logic [7:0] FC_RD_HOLD  = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL  = 8'h05;
  localparam logic [7:0] FC_WR_REG   = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_REGS  = 8'h10;
  localparam logic [7:0] EXC_FUNC    = 8'h01;
  localparam logic [7:0] EXC_ADDR    = 8'h02;
  localparam logic [7:0] EXC_VALUE   = 8'h03;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_COILS  = 64;
  localparam int unsigned NUM_WORDS  = 8;
  localparam logic [15:0] MAX_POINTS = 16'h07d0;
  localparam int unsigned BUF_DEPTH  = 16;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } byte_beat_t;
endpackage

// ===== mb_req_store.sv
// Request byte store with registered read port
`timescale 1ns/100ps
module mb_req_store #(
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [7:0]               wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output      logic [7:0]               rdData
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// ===== modbus_frame_responder.sv
// Slave-side frame responder: receives a request frame and builds the reply
// ----------------------------------------------------------------
// Summary of operation
// R1: Reply is produced only after a received request frame ends.
// R2: In TCP mode the body starts after a six-byte header.
// R3: Master picks the transaction identifier; it is echoed back unchanged.
// R4: Protocol identifier and length high byte are zero on send and receive.
// R5: Header length low byte delimits the body; reply carries its own count.
// R6: First body byte is station address; zero means broadcast, 1..247 individual.
// R7: Second body byte is the function selector, 1 to 255.
// R8: Successful reply echoes the request selector unchanged.
// R9: Failure reply sets the selector top bit.
// R10: Selectors 01..06, 0F, 10 are accepted; others raise an exception.
// R11: 16-bit values are sent high byte first.
// R12: 32-bit values travel low word first, each word high byte first.
// R13: A body with no data after the selector is accepted.
// R14: Inputs come from digital points; words from analog inputs and outputs.
// R15: Coil read request holds start and count, high byte first.
// R16: Coil read byte count is (points plus seven) divided by eight.
// R17: Coil bits packed eight per byte from byte three, lowest point bit zero.
// R18: Failed coil read answers address, 0x81 and one exception byte.
// R19: Foreign station addresses are dropped with no reply.
// R20: Station address switch is 1..31; zero acts as one.
// ----------------------------------------------------------------
`timescale 1ns/100ps
module modbus_frame_responder (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        tcpMode,
  input  wire logic [4:0]                  stationAddress,
  input  wire mb_pkg::byte_beat_t          rxBeat,
  output      mb_pkg::byte_beat_t          txBeat,
  input  wire logic                        txReady,
  input  wire logic [mb_pkg::NUM_COILS-1:0] digitalInputPoint,
  input  wire logic [15:0]                 analogInputWord [mb_pkg::NUM_WORDS],
  output      logic [mb_pkg::NUM_COILS-1:0] coilOut,
  output      logic [15:0]                 analogOutputWord [mb_pkg::NUM_WORDS],
  output      logic                        frameDone,
  output      logic                        frameDropped
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {IDLE, RECV, FETCH, EXEC, SEND} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [4:0]  sw1;
    logic [4:0]  sw2;
    logic [4:0]  rxCnt;
    logic [3:0]  rdIdx;
    logic [5:0][7:0] body;
    logic [15:0] tid;
    logic        hdrBad;
    logic [7:0]  txCnt;
    logic [7:0]  txLen;
    logic [7:0]  fc;
    logic [7:0]  exc;
    logic [7:0]  addr;
    logic        tcp;
    logic [7:0]  txData;
    logic        txValid;
    logic        txLast;
    logic [mb_pkg::NUM_COILS-1:0] coils;
    logic [mb_pkg::NUM_WORDS-1:0][15:0] aout;
    logic        done;
    logic        drop;
    logic [7:0]  bodyLen;
    logic [mb_pkg::NUM_COILS-1:0] din1;
    logic [mb_pkg::NUM_COILS-1:0] din2;
    // Words pass two flops as a whole; one changing mid-sample may be torn
    logic [mb_pkg::NUM_WORDS-1:0][15:0] ain1;
    logic [mb_pkg::NUM_WORDS-1:0][15:0] ain2;
  } st_t;

  st_t cur;
  st_t next_cur;
  logic [7:0] memData;
  logic [7:0] rxByte;
  logic [15:0] start;
  logic [15:0] count;
  logic [4:0] ownAddr;
  logic [7:0] coilBytes;

  // The first 16 request bytes land in the store at their receive index; its read data is not used
  mb_req_store #(.DEPTH(mb_pkg::BUF_DEPTH)) reqStore (
    .clk    (clk),
    .we     (rxBeat.valid && cur.phase inside {IDLE, RECV}),
    .wrAddr (cur.rxCnt[3:0]),
    .wrData (rxBeat.data),
    .rdAddr (cur.rdIdx),
    .rdData (memData)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // R20: zero switch acts as one
  assign ownAddr   = (cur.sw2 == 5'h00) ? mb_pkg::OWN_DEFAULT : cur.sw2;
  // R15: start and count high byte first
  assign start     = {cur.body[2], cur.body[3]};
  assign count     = {cur.body[4], cur.body[5]};
  // R16: truncating divide by eight
  assign coilBytes = 8'((count + 16'h0007) >> 3);
  assign rxByte    = rxBeat.data;

  function automatic logic [7:0] txByteAt(input st_t s, input logic [7:0] k,
                                          input logic [15:0] st, input logic [7:0] nb);
    logic [7:0]  b;
    logic [15:0] base;
    logic [15:0] w;
    logic [4:0]  wi;
    b    = 8'h00;
    base = 16'h0000;
    w    = 16'h0000;
    wi   = 5'h00;
    if (s.tcp && k < 8'(mb_pkg::HDR_LEN)) begin
      // R3: echo the master's identifier
      // R4: zero protocol id and length high byte
      // R5: length low byte counts body bytes
      unique case (k[2:0])
        3'h0:    b = s.tid[15:8];
        3'h1:    b = s.tid[7:0];
        3'h2:    b = mb_pkg::PROTO_ID;
        3'h3:    b = mb_pkg::PROTO_ID;
        3'h4:    b = mb_pkg::LEN_HI;
        default: b = 8'(s.txLen - 8'(mb_pkg::HDR_LEN));
      endcase
    end else begin
      logic [7:0] j;
      j = s.tcp ? 8'(k - 8'(mb_pkg::HDR_LEN)) : k;
      if (j == 8'h00) begin
        b = s.addr;
      end else if (j == 8'h01) begin
        // R8: echo selector on success
        // R9: error flag in top bit on failure
        b = (s.exc != 8'h00) ? (s.fc | mb_pkg::ERR_BIT) : s.fc;
      end else if (s.exc != 8'h00) begin
        // R18: single exception byte
        b = s.exc;
      end else if (s.fc inside {mb_pkg::FC_RD_COIL, mb_pkg::FC_RD_DIN}) begin
        if (j == 8'h02) begin
          b = nb;
        end else begin
          // R17: eight points per byte, lowest in bit zero
          base = 16'(st + {5'h00, 8'(j - 8'(mb_pkg::COIL_DATA_AT)), 3'h0});
          for (int i = 0; i < 8; i++) begin
            w  = 16'(base + 16'(i));
            // R14: inputs from digital points, coils from output latches
            // Points past the requested count read as zero
            if (w < 16'(mb_pkg::NUM_COILS) && w < 16'(st + {s.body[4], s.body[5]})) begin
              b[i] = (s.fc == mb_pkg::FC_RD_COIL) ? s.coils[w[5:0]] : s.din2[w[5:0]];
            end
          end
        end
      end else if (s.fc inside {mb_pkg::FC_RD_HOLD, mb_pkg::FC_RD_INREG}) begin
        if (j == 8'h02) begin
          // Two bytes per word
          b = 8'({s.body[4], s.body[5]} << 1);
        end else begin
          // R12: a 32-bit pair is two words in address order, low word first
          wi = 5'(st + 16'((j - 8'h03) >> 1));
          w  = (s.fc == mb_pkg::FC_RD_INREG) ? s.ain2[wi[2:0]] : s.aout[wi[2:0]];
          // R11: high byte first
          b  = j[0] ? w[15:8] : w[7:0];
        end
      end else begin
        // Write replies echo address and value or quantity fields
        b = s.body[j[2:0]];
      end
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] bodyIdx;
    logic       bad;
    bodyIdx  = 8'h00;
    bad      = 1'b0;
    next_cur = cur;
    next_cur.sw1  = stationAddress;
    next_cur.sw2  = cur.sw1;
    // R14: input points and words pass two flops before the reply reads them
    next_cur.din1 = digitalInputPoint;
    next_cur.din2 = cur.din1;
    next_cur.ain2 = cur.ain1;
    for (int g = 0; g < mb_pkg::NUM_WORDS; g++) begin
      next_cur.ain1[g] = analogInputWord[g];
    end
    next_cur.done = 1'b0;
    next_cur.drop = 1'b0;
    unique case (cur.phase)
      IDLE, RECV: begin
        // R1: nothing is sent until a request arrives
        if (rxBeat.valid) begin
          next_cur.phase = RECV;
          next_cur.tcp   = (cur.phase == IDLE) ? tcpMode : cur.tcp;
          next_cur.rxCnt = 5'(cur.rxCnt + ((cur.rxCnt == 5'h1f) ? 5'h00 : 5'h01));
          // R2: body follows the header in TCP mode
          bodyIdx = next_cur.tcp ? 8'(cur.rxCnt - 5'(mb_pkg::HDR_LEN)) : 8'(cur.rxCnt);
          if (next_cur.tcp && cur.rxCnt == 5'h00) next_cur.tid[15:8] = rxByte;
          if (next_cur.tcp && cur.rxCnt == 5'h01) next_cur.tid[7:0] = rxByte;
          // R4: nonzero protocol id or length high byte is malformed
          if (next_cur.tcp && cur.rxCnt inside {5'h02, 5'h03, 5'h04} && rxByte != 8'h00)
            next_cur.hdrBad = 1'b1;
          // R5: length low byte gives the body size
          if (next_cur.tcp && cur.rxCnt == 5'h05) next_cur.bodyLen = rxByte;
          if (bodyIdx < 8'd6 && !(next_cur.tcp && cur.rxCnt < 5'(mb_pkg::HDR_LEN)))
            next_cur.body[bodyIdx[2:0]] = rxByte;
          // R13: a frame may end right after the selector
          if (rxBeat.last) begin
            next_cur.phase = EXEC;
            next_cur.rdIdx = 4'h0;
            // R5: body size must match; frames past the saturated count skip the check
            if (next_cur.tcp && cur.rxCnt != 5'h1f &&
                8'(cur.rxCnt) + 8'h01 != 8'(mb_pkg::HDR_LEN) + next_cur.bodyLen)
              next_cur.hdrBad = 1'b1;
          end
        end
      end
      FETCH: next_cur.phase = EXEC;
      EXEC: begin
        next_cur.addr  = cur.body[0];
        next_cur.fc    = cur.body[1];
        next_cur.exc   = 8'h00;
        next_cur.rxCnt = 5'h00;
        next_cur.hdrBad = 1'b0;
        // R7: selector zero is no valid request
        // R6: broadcast or own address; R19: drop others
        if (cur.hdrBad || (cur.body[0] != mb_pkg::ADDR_BCAST &&
                           cur.body[0] != {3'h0, ownAddr}) || cur.body[1] == 8'h00) begin
          next_cur.phase = IDLE;
          next_cur.drop  = 1'b1;
        end else begin
          // R10: supported selectors only
          unique case (cur.body[1])
            mb_pkg::FC_RD_COIL, mb_pkg::FC_RD_DIN: begin
              bad = count == 16'h0000 || count > mb_pkg::MAX_POINTS;
              if (!bad && 17'(start) + 17'(count) > 17'(mb_pkg::NUM_COILS))
                next_cur.exc = mb_pkg::EXC_ADDR;
              next_cur.txLen = 8'(3) + coilBytes;
            end
            mb_pkg::FC_RD_HOLD, mb_pkg::FC_RD_INREG: begin
              bad = count == 16'h0000 || count > 16'(mb_pkg::NUM_WORDS);
              if (!bad && 17'(start) + 17'(count) > 17'(mb_pkg::NUM_WORDS))
                next_cur.exc = mb_pkg::EXC_ADDR;
              next_cur.txLen = 8'(8'h03 + 8'(count << 1));
            end
            mb_pkg::FC_WR_COIL: begin
              if (start >= 16'(mb_pkg::NUM_COILS)) next_cur.exc = mb_pkg::EXC_ADDR;
              else if (count == 16'hff00) next_cur.coils[start[5:0]] = 1'b1;
              else if (count == 16'h0000) next_cur.coils[start[5:0]] = 1'b0;
              else bad = 1'b1;
              next_cur.txLen = 8'(mb_pkg::REQ_LEN);
            end
            mb_pkg::FC_WR_REG: begin
              if (start >= 16'(mb_pkg::NUM_WORDS)) next_cur.exc = mb_pkg::EXC_ADDR;
              else next_cur.aout[start[2:0]] = count;
              next_cur.txLen = 8'(mb_pkg::REQ_LEN);
            end
            mb_pkg::FC_WR_COILS, mb_pkg::FC_WR_REGS: begin
              // Payload bytes are not applied to coils or words; acknowledge only
              next_cur.txLen = 8'(mb_pkg::REQ_LEN);
            end
            default: next_cur.exc = mb_pkg::EXC_FUNC;
          endcase
          if (bad) next_cur.exc = mb_pkg::EXC_VALUE;
          if (next_cur.exc != 8'h00) next_cur.txLen = 8'h03;
          if (cur.tcp) next_cur.txLen = 8'(next_cur.txLen + 8'(mb_pkg::HDR_LEN));
          if (cur.body[0] == mb_pkg::ADDR_BCAST) begin
            next_cur.phase = IDLE;
            next_cur.done  = 1'b1;
          end else begin
            next_cur.phase = SEND;
            next_cur.txCnt = 8'h00;
          end
        end
      end
      SEND: begin
        if (!cur.txValid || txReady) begin
          if (cur.txValid && cur.txLast) begin
            next_cur.phase   = IDLE;
            next_cur.txValid = 1'b0;
            next_cur.txLast  = 1'b0;
            next_cur.done    = 1'b1;
          end else begin
            next_cur.txValid = 1'b1;
            next_cur.txData  = txByteAt(cur, cur.txCnt, start, coilBytes);
            next_cur.txLast  = cur.txCnt == 8'(cur.txLen - 8'h01);
            next_cur.txCnt   = 8'(cur.txCnt + 8'h01);
          end
        end
      end
      default: next_cur.phase = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign txBeat           = '{valid: cur.txValid, last: cur.txLast, data: cur.txData};
  assign coilOut          = cur.coils;
  for (genvar g = 0; g < mb_pkg::NUM_WORDS; g++) begin
    assign analogOutputWord[g] = cur.aout[g];
  end
  assign frameDone        = cur.done;
  assign frameDropped     = cur.drop;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  no_unsolicited_a: assert property (txBeat.valid |-> cur.phase == SEND) // R1
    else $error("Reply byte outside reply phase");
  foreign_drop_a: assert property (frameDropped |-> !txBeat.valid) // R19
    else $error("Reply to a dropped frame");
  err_bit_a: assert property (cur.phase == SEND && cur.exc != 8'h00 && txBeat.valid // R9
                              && cur.txCnt == (cur.tcp ? 8'h08 : 8'h02)
                              |-> txBeat.data == (cur.fc | mb_pkg::ERR_BIT))
    else $error("Exception reply without top bit");
  hold_until_ready_a: assert property (txBeat.valid && !txReady |=> $stable(txBeat.data)) // reply byte held while the sink stalls
    else $error("Reply byte changed while stalled");
  bcast_silent_a: assert property (cur.phase == EXEC && cur.body[0] == 8'h00 |=> cur.phase != SEND) // R6
    else $error("Broadcast answered");
  len_a: assert property (cur.phase == EXEC |=> cur.phase != SEND || cur.txLen >= 8'h03) // R16
    else $error("Reply too short");
  last_a: assert property (txBeat.valid && txBeat.last && txReady |=> !txBeat.valid) // R5
    else $error("Byte after last");
  own_addr_a: assert property (ownAddr != 5'h00) // R20
    else $error("Own address zero");
  cv_reply_c: cover property (txBeat.valid && txBeat.last && txReady);
  cv_drop_c: cover property (frameDropped);
  cv_exc_c: cover property (cur.phase == SEND && cur.exc != 8'h00);
  cv_tcp_c: cover property (cur.phase == SEND && cur.tcp);
endmodule

// ===== tb_top.sv
// Testbench: scenario tasks driving the frame responder through a master model
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin nMismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  logic                         clk;
  logic                         arst_n;
  logic                         tcpMode;
  logic [4:0]                   stationAddress;
  mb_pkg::byte_beat_t           rxBeat;
  mb_pkg::byte_beat_t           txBeat;
  logic                         txReady;
  logic [mb_pkg::NUM_COILS-1:0] digitalInputPoint;
  logic [15:0]                  analogInputWord [mb_pkg::NUM_WORDS];
  logic [mb_pkg::NUM_COILS-1:0] coilOut;
  logic [15:0]                  analogOutputWord [mb_pkg::NUM_WORDS];
  logic                         frameDone;
  logic                         frameDropped;
  int                           nMismatch;
  int                           compares;
  int                           nDone;
  int                           nDrop;
  int                           cycles;

  modbus_frame_responder DUT (.clk(clk), .arst_n(arst_n), .tcpMode(tcpMode),
    .stationAddress(stationAddress), .rxBeat(rxBeat), .txBeat(txBeat), .txReady(txReady),
    .digitalInputPoint(digitalInputPoint), .analogInputWord(analogInputWord),
    .coilOut(coilOut), .analogOutputWord(analogOutputWord), .frameDone(frameDone),
    .frameDropped(frameDropped));
  mb_master_model master (.clk(clk), .rxBeat(rxBeat), .txBeat(txBeat), .txReady(txReady));

  // ----------------------------------------------------------------
  // Clock, pulse counters and hang guard
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // Pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (frameDone === 1'b1) nDone++;
    if (frameDropped === 1'b1) nDrop++;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      nMismatch++;
      wrapUp;
    end
  end

  task automatic wrapUp;
    $display("compares %0d mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Shared transfers
  // ----------------------------------------------------------------
  task automatic xact(input logic [7:0] req [$], input logic [7:0] exp [$], input bit slow);
    logic [7:0] got [$];
    bit         ok;
    int         d0;
    d0 = nDone;
    master.send(req);
    master.recv(slow, got, ok);
    repeat (3) @(posedge clk);
    #1;
    `CHK(ok, 1'b1)
    `CHK(got.size(), exp.size())
    for (int i = 0; i < exp.size() && i < got.size(); i++) `CHK(got[i], exp[i])
    `CHK(nDone - d0, 1)
  endtask

  task automatic silent(input logic [7:0] req [$], input bit drop);
    int d0;
    int p0;
    int seen;
    d0   = nDone;
    p0   = nDrop;
    seen = 0;
    master.send(req);
    repeat (10) begin
      @(negedge clk);
      if (txBeat.valid === 1'b1) seen++;
    end
    `CHK(seen, 0)
    `CHK(nDrop - p0, int'(drop))
    `CHK(nDone - d0, int'(!drop))
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tCoils;
    xact({8'h01, 8'h05, 8'h00, 8'h03, 8'hff, 8'h00}, {8'h01, 8'h05, 8'h00, 8'h03, 8'hff, 8'h00}, 0);
    xact({8'h01, 8'h05, 8'h00, 8'h0a, 8'hff, 8'h00}, {8'h01, 8'h05, 8'h00, 8'h0a, 8'hff, 8'h00}, 1);
    `CHK(coilOut, 64'h0000_0000_0000_0408)
    xact({8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h0c}, {8'h01, 8'h01, 8'h02, 8'h08, 8'h04}, 1);
    $display("test coils done");
  endtask

  task automatic tAddressing;
    silent({8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08}, 1);
    silent({8'h00, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00}, 0);
    `CHK(coilOut, 64'h0000_0000_0000_0409)
    @(posedge clk);
    #1;
    stationAddress = 5'h05;
    repeat (4) @(posedge clk);
    #1;
    xact({8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08}, {8'h05, 8'h01, 8'h01, 8'h09}, 0);
    $display("test addressing done");
  endtask

  task automatic tWords;
    tcpMode = 1'b1;
    xact({8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h06, 8'h05, 8'h06, 8'h00, 8'h02, 8'h0c, 8'h0d},
         {8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h06, 8'h05, 8'h06, 8'h00, 8'h02, 8'h0c, 8'h0d},
         1);
    tcpMode = 1'b0;
    xact({8'h05, 8'h06, 8'h00, 8'h03, 8'h0a, 8'h0b}, {8'h05, 8'h06, 8'h00, 8'h03, 8'h0a, 8'h0b}, 0);
    `CHK(analogOutputWord[2], 16'h0c0d)
    tcpMode = 1'b1;
    xact({8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h06, 8'h05, 8'h03, 8'h00, 8'h02, 8'h00, 8'h02},
         {8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h07, 8'h05, 8'h03, 8'h04, 8'h0c, 8'h0d, 8'h0a,
          8'h0b}, 1);
    silent({8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h06, 8'h05, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00},
           1);
    silent({8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h05, 8'h05, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00},
           1);
    `CHK(coilOut, 64'h0000_0000_0000_0409)
    @(posedge clk);
    #1;
    tcpMode = 1'b0;
    $display("test words done");
  endtask

  task automatic tSelectors;
    logic [7:0] got [$];
    bit         ok;
    xact({8'h05, 8'h07}, {8'h05, 8'h87, 8'h01}, 0);
    xact({8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, {8'h05, 8'h81, 8'h03}, 0);
    xact({8'h05, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01, 8'h03},
         {8'h05, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h02}, 0);
    xact({8'h05, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34},
         {8'h05, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01}, 0);
    for (int k = 2; k <= 4; k++) begin
      master.send({8'h05, 8'(k), 8'h00, 8'h00, 8'h00, 8'h01});
      master.recv(1'b0, got, ok);
      repeat (3) @(posedge clk);
      #1;
      `CHK(got.size(), (k == 2) ? 4 : 5)
      `CHK(got[1], 8'(k))
      `CHK(got[2], (k == 2) ? 8'h01 : 8'h02)
      `CHK(got[3], (k == 3) ? 8'h00 : 8'h01)
    end
    $display("test selectors done");
  endtask

  initial begin
    arst_n            = 1'b0;
    tcpMode           = 1'b0;
    stationAddress    = 5'h00;
    digitalInputPoint = 64'h0000_0000_0000_00a5;
    foreach (analogInputWord[i]) analogInputWord[i] = 16'h0100 + 16'(i);
    repeat (4) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge clk);
    tCoils;
    tAddressing;
    tWords;
    tSelectors;
    wrapUp;
  end
endmodule
